// ---- verilog/adcr_defines.vh ----
// Register offsets, field layout and reset values of the drive config bank
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH

`define ADCR_ADDR_W              8

`define ADCR_OFS_PERIOD_HIGH     8'h0A
`define ADCR_OFS_PERIOD_LOW      8'h0B
`define ADCR_OFS_NOMINAL_VOLT    8'h0C
`define ADCR_OFS_ABS_VOLT        8'h0D
`define ADCR_OFS_MAX_CURRENT     8'h0E
`define ADCR_OFS_SCALE_HIGH      8'h0F
`define ADCR_OFS_SCALE_LOW       8'h10

`define ADCR_RST_PERIOD_HIGH     8'h21
`define ADCR_RST_PERIOD_LOW      7'h4F
`define ADCR_RST_NOMINAL_VOLT    8'h5A
`define ADCR_RST_ABS_VOLT        8'h78
`define ADCR_RST_MAX_CURRENT     5'h17
`define ADCR_RST_SCALE_HIGH      8'h01
`define ADCR_RST_SCALE_LOW       8'h0D

`define ADCR_PERIOD_LOW_W        7
`define ADCR_PERIOD_W            15
`define ADCR_MAX_CURRENT_W       5
`define ADCR_SCALE_W             16

`endif

// ---- verilog/adcr_regs.v ----
// Actuator drive configuration registers and their drive-side outputs
`timescale 1ns/1ps
`default_nettype none
`include "adcr_defines.vh"

// Operation
// (RL1) Period value is 128 times upper plus lower
// (RL2) Programmed period is the initial drive period
// (RL3) Period resets to 0x21 / 0x4F, 174 Hz
// (RL4) Nominal voltage code, 23.4 mV steps, reset 0x5A
// (RL5) Acceleration on: nominal voltage is full scale
// (RL6) Absolute limit code, 23.4 mV steps, reset 0x78
// (RL7) Acceleration on: overdrive clamped to absolute limit
// (RL8) Acceleration off: absolute limit is full scale
// (RL9) Max current in bits 4:0, reset 0x17
// (RL10) Scale factor is upper and lower byte concatenated
// (RL11) Scale upper byte resets to 0x01
// (RL12) Scale lower byte at next offset, reset 0x0D
module adcr_regs (
	input  wire                          ref_clk,
	input  wire                          rst,
	input  wire [`ADCR_ADDR_W-1:0]       reg_addr,
	input  wire                          reg_wr_en,
	input  wire [7:0]                    reg_wdata,
	input  wire                          reg_rd_en,
	output reg  [7:0]                    reg_rdata,
	output reg                           reg_rd_valid,
	output reg                           reg_hit,
	input  wire                          acceleration_en,
	input  wire [7:0]                    sample_in,
	input  wire                          sample_valid,
	input  wire [7:0]                    overdrive_in,
	output reg  [`ADCR_PERIOD_W-1:0]     resonant_period_value,
	output reg                           period_update,
	output reg  [7:0]                    full_scale_level,
	output reg  [7:0]                    scaled_sample,
	output reg                           scaled_valid,
	output reg  [7:0]                    overdrive_level,
	output reg  [`ADCR_MAX_CURRENT_W-1:0] max_current_code,
	output reg  [`ADCR_SCALE_W-1:0]      impedance_scale_value
);

	// ************************************************************
	// Storage
	// ************************************************************
	reg [7:0]                     period_upper_byte;
	reg [`ADCR_PERIOD_LOW_W-1:0]  period_lower_field;
	reg [7:0]                     nominal_voltage_rating;
	reg [7:0]                     absolute_voltage_limit;
	reg [`ADCR_MAX_CURRENT_W-1:0] max_current_rating;
	reg [7:0]                     impedance_scale_upper;
	reg [7:0]                     impedance_scale_lower;

	// ************************************************************
	// Decode
	// ************************************************************
	wire sel_per_h = (reg_addr == `ADCR_OFS_PERIOD_HIGH);
	wire sel_per_l = (reg_addr == `ADCR_OFS_PERIOD_LOW);
	wire sel_nom   = (reg_addr == `ADCR_OFS_NOMINAL_VOLT);
	wire sel_abs   = (reg_addr == `ADCR_OFS_ABS_VOLT);
	wire sel_cur   = (reg_addr == `ADCR_OFS_MAX_CURRENT);
	wire sel_sc_h  = (reg_addr == `ADCR_OFS_SCALE_HIGH);
	wire sel_sc_l  = (reg_addr == `ADCR_OFS_SCALE_LOW);
	wire sel_any   = sel_per_h | sel_per_l | sel_nom | sel_abs |
		sel_cur | sel_sc_h | sel_sc_l;

	// ************************************************************
	// Register writes
	// ************************************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			period_upper_byte      <= `ADCR_RST_PERIOD_HIGH; // RL3
			period_lower_field     <= `ADCR_RST_PERIOD_LOW; // RL3
			nominal_voltage_rating <= `ADCR_RST_NOMINAL_VOLT; // RL4
			absolute_voltage_limit <= `ADCR_RST_ABS_VOLT; // RL6
			max_current_rating     <= `ADCR_RST_MAX_CURRENT; // RL9
			impedance_scale_upper  <= `ADCR_RST_SCALE_HIGH; // RL11
			impedance_scale_lower  <= `ADCR_RST_SCALE_LOW; // RL12
		end else if (reg_wr_en) begin
			if (sel_per_h) begin
				period_upper_byte <= reg_wdata;
			end
			if (sel_per_l) begin
				period_lower_field <= reg_wdata[`ADCR_PERIOD_LOW_W-1:0];
			end
			if (sel_nom) begin
				nominal_voltage_rating <= reg_wdata; // RL4
			end
			if (sel_abs) begin
				absolute_voltage_limit <= reg_wdata; // RL6
			end
			if (sel_cur) begin
				max_current_rating <=
					reg_wdata[`ADCR_MAX_CURRENT_W-1:0]; // RL9
			end
			if (sel_sc_h) begin
				impedance_scale_upper <= reg_wdata; // RL11
			end
			if (sel_sc_l) begin
				impedance_scale_lower <= reg_wdata; // RL12
			end
		end
	end

	// ************************************************************
	// Register reads
	// ************************************************************
	reg [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		case (1'h1)
		sel_per_h: next_rdata = period_upper_byte;
		sel_per_l: next_rdata = {1'h0, period_lower_field};
		sel_nom:   next_rdata = nominal_voltage_rating;
		sel_abs:   next_rdata = absolute_voltage_limit;
		sel_cur:   next_rdata = {3'h0, max_current_rating};
		sel_sc_h:  next_rdata = impedance_scale_upper;
		sel_sc_l:  next_rdata = impedance_scale_lower;
		default:   next_rdata = 8'h00;
		endcase
	end

	// Valid follows the read strobe one cycle later; data and hit hold until the next read
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rd_valid <= 1'h0;
		end else begin
			reg_rd_valid <= reg_rd_en;
		end
	end

	// Unmapped offsets answer zero with reg_hit low
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_hit   <= 1'h0;
		end else if (reg_rd_en) begin
			reg_rdata <= next_rdata;
			reg_hit   <= sel_any;
		end
	end

	// ************************************************************
	// Derived configuration values
	// ************************************************************
	// Upper byte shifted by seven is the same as times 128
	wire [`ADCR_PERIOD_W-1:0] next_period =
		{period_upper_byte, period_lower_field}; // RL1

	// Mode picks which voltage code means full scale
	wire [7:0] next_full_scale = acceleration_en ?
		nominal_voltage_rating : // RL5
		absolute_voltage_limit; // RL8

	// A period write reaches storage one edge before the period output
	// follows it, so the restart strobe is delayed to stand with it
	reg period_written;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			period_written        <= 1'h0;
			resonant_period_value <= {`ADCR_RST_PERIOD_HIGH,
				`ADCR_RST_PERIOD_LOW};
			// Reset counts as a restart from the default period
			period_update         <= 1'h1;
		end else begin
			period_written <= reg_wr_en & (sel_per_h | sel_per_l);
			resonant_period_value <= next_period; // RL2
			// Tells the tracking loop to restart from the new period
			period_update         <= period_written; // RL2
		end
	end

	// ************************************************************
	// Voltage, current and impedance scale outputs
	// ************************************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// Absolute limit is the safe full scale before mode is known
			full_scale_level      <= `ADCR_RST_ABS_VOLT;
			max_current_code      <= `ADCR_RST_MAX_CURRENT;
			impedance_scale_value <= {`ADCR_RST_SCALE_HIGH,
				`ADCR_RST_SCALE_LOW};
		end else begin
			full_scale_level      <= next_full_scale; // RL5 RL8
			max_current_code      <= max_current_rating; // RL9
			impedance_scale_value <= {impedance_scale_upper,
				impedance_scale_lower}; // RL10
		end
	end

	// ************************************************************
	// Sample scaling and overdrive clamp
	// ************************************************************
	// Truncating the product keeps a 0xFF sample one step under full
	// scale; cheaper than a true divide by 255
	wire [15:0] sample_product = sample_in * next_full_scale;

	wire [7:0] next_overdrive =
		(acceleration_en && (overdrive_in > absolute_voltage_limit)) ?
		absolute_voltage_limit : overdrive_in; // RL7

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scaled_sample <= 8'h00;
			scaled_valid  <= 1'h0;
		end else begin
			scaled_valid <= sample_valid; // RL5 RL8
			if (sample_valid) begin
				scaled_sample <= sample_product[15:8]; // RL5 RL8
			end
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overdrive_level <= 8'h00;
		end else begin
			overdrive_level <= next_overdrive; // RL7
		end
	end

endmodule
`default_nettype wire

// ---- verification/adcr_regs_chk.sv ----
// Port checker for the actuator drive configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "adcr_defines.vh"
module adcr_regs_chk (
	input wire        ref_clk,
	input wire        rst,
	input wire        reg_wr_en,
	input wire        reg_rd_en,
	input wire        reg_rd_valid,
	input wire        reg_hit,
	input wire        acceleration_en,
	input wire        period_update,
	input wire        sample_valid,
	input wire        scaled_valid,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata,
	input wire [7:0]  overdrive_in,
	input wire [7:0]  overdrive_level,
	input wire [14:0] resonant_period_value,
	input wire [4:0]  max_current_code,
	input wire [15:0] impedance_scale_value
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Derived outputs land two edges after the write strobe
	per_hi_a: assert property (
		reg_wr_en && reg_addr == 8'h0A |-> ##2
		resonant_period_value[14:7] == $past(reg_wdata, 2))
		else $error("upper period");
	per_lo_a: assert property (
		reg_wr_en && reg_addr == 8'h0B |-> ##2
		resonant_period_value[6:0] == $past(reg_wdata[6:0], 2))
		else $error("lower period");
	// Restart strobe stands with the new period, not a cycle ahead
	per_restart_a: assert property (
		reg_wr_en && reg_addr[7:1] == 7'h05 |-> ##2 period_update)
		else $error("no period restart");
	restart_cause_a: assert property (
		period_update && !$past(rst) |->
		$past(reg_wr_en, 2) && ($past(reg_addr, 2) >> 1) == 8'h05)
		else $error("stray period restart");
	cur_field_a: assert property (
		reg_wr_en && reg_addr == 8'h0E |-> ##2
		max_current_code == $past(reg_wdata[4:0], 2))
		else $error("current code");
	scale_hi_a: assert property (
		reg_wr_en && reg_addr == 8'h0F |-> ##2
		impedance_scale_value[15:8] == $past(reg_wdata, 2))
		else $error("scale hi");
	scale_lo_a: assert property (
		reg_wr_en && reg_addr == 8'h10 |-> ##2
		impedance_scale_value[7:0] == $past(reg_wdata, 2))
		else $error("scale lo");
	clamp_on_a: assert property (
		acceleration_en |=> overdrive_level <= $past(overdrive_in))
		else $error("overdrive raised");
	pass_off_a: assert property (
		!acceleration_en |=> overdrive_level == $past(overdrive_in))
		else $error("overdrive changed");
	rd_unmap_a: assert property (
		reg_rd_en && reg_addr > 8'h10 |=>
		reg_rd_valid && !reg_hit && reg_rdata == 8'h00)
		else $error("unmapped read");
	scaled_pulse_a: assert property (
		scaled_valid == $past(sample_valid))
		else $error("scaled valid not a one-cycle echo");
endmodule
bind adcr_regs adcr_regs_chk adcr_regs_chk_i (
	.ref_clk(ref_clk),
	.rst(rst),
	.reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en),
	.reg_rd_valid(reg_rd_valid),
	.reg_hit(reg_hit),
	.acceleration_en(acceleration_en),
	.period_update(period_update),
	.sample_valid(sample_valid),
	.scaled_valid(scaled_valid),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.overdrive_in(overdrive_in),
	.overdrive_level(overdrive_level),
	.resonant_period_value(resonant_period_value),
	.max_current_code(max_current_code),
	.impedance_scale_value(impedance_scale_value)
);
`default_nettype wire

// ---- verification/adcr_regs_tb.sv ----
// Self-checking bench for the actuator drive configuration bank
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_tb;
	reg ref_clk = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0;
	reg acceleration_en = 0, sample_valid = 0;
	reg [7:0] reg_addr = 0, reg_wdata = 0, sample_in = 0, overdrive_in = 0;
	wire [7:0] reg_rdata, full_scale_level, scaled_sample, overdrive_level;
	wire reg_rd_valid, reg_hit, period_update, scaled_valid;
	wire [14:0] resonant_period_value;
	wire [4:0] max_current_code;
	wire [15:0] impedance_scale_value;
	integer errors = 0, tests_run = 0, cycles = 0, k;
	reg [23:0] rows [0:14];
	always #12.5 ref_clk = ~ref_clk;
	adcr_regs adcr_regs_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit),
		.acceleration_en(acceleration_en), .sample_in(sample_in),
		.sample_valid(sample_valid), .overdrive_in(overdrive_in),
		.resonant_period_value(resonant_period_value),
		.period_update(period_update), .full_scale_level(full_scale_level),
		.scaled_sample(scaled_sample), .scaled_valid(scaled_valid),
		.overdrive_level(overdrive_level), .max_current_code(max_current_code),
		.impedance_scale_value(impedance_scale_value));
	task summarize; begin
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end endtask
	task chk(input [15:0] got, input [15:0] exp); begin
		tests_run = tests_run + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	end endtask
	task tick(input integer n); begin repeat (n) @(posedge ref_clk); #1; end endtask
	task wr(input [7:0] a, input [7:0] d); begin
		reg_addr = a; reg_wdata = d; reg_wr_en = 1; tick(1); reg_wr_en = 0;
	end endtask
	task rd(input [7:0] a); begin
		reg_addr = a; reg_rd_en = 1; tick(1); reg_rd_en = 0;
		chk(reg_rd_valid, 1'b1);
	end endtask
	// Timeout well above the forty or so cycles the run needs
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 1000) begin
			errors = errors + 1;
			summarize;
		end
	end
	initial begin
		// Address, write data, expected readback; rows 8 on are reset values
		rows[0] = 24'h0A3030; rows[1] = 24'h0BFF7F; rows[2] = 24'h0C1111;
		rows[3] = 24'h0D4040; rows[4] = 24'h0EFF1F; rows[5] = 24'h0F2222;
		rows[6] = 24'h103333; rows[7] = 24'h205500; rows[8] = 24'h0A0021;
		rows[9] = 24'h0B004F; rows[10] = 24'h0C005A; rows[11] = 24'h0D0078;
		rows[12] = 24'h0E0017; rows[13] = 24'h0F0001; rows[14] = 24'h10000D;
		tick(6);
		rst = 0;
		for (k = 0; k < 8; k = k + 1) begin
			wr(rows[k][23:16], rows[k][15:8]);
			rd(rows[k][23:16]);
			chk(reg_rdata, rows[k][7:0]);
			chk(reg_hit, rows[k][23:16] != 8'h20);
			chk(period_update, rows[k][23:17] == 7'h05);
		end
		chk(resonant_period_value, {8'h30, 7'h7F});
		chk(max_current_code, 5'h1F);
		chk(impedance_scale_value, 16'h2233);
		// Restart pulse must stand together with the new period
		wr(8'h0A, 8'h21);
		tick(1);
		chk(period_update, 1'h1);
		chk(resonant_period_value, {8'h21, 7'h7F});
		tick(1);
		chk(period_update, 1'h0);
		acceleration_en = 1; overdrive_in = 8'h50; tick(2);
		chk(full_scale_level, 8'h11);
		chk(overdrive_level, 8'h40);
		sample_in = 8'hFF; sample_valid = 1; tick(1); sample_valid = 0;
		chk(scaled_sample, 8'h10);
		acceleration_en = 0; tick(2);
		chk(full_scale_level, 8'h40);
		chk(overdrive_level, 8'h50);
		sample_in = 8'h80; sample_valid = 1; tick(1); sample_valid = 0;
		chk(scaled_valid, 1'b1);
		chk(scaled_sample, 8'h20);
		rst = 1; #1;
		chk(resonant_period_value, 15'h10CF);
		chk(period_update, 1'b1);
		chk(impedance_scale_value, 16'h010D);
		tick(1); rst = 0;
		for (k = 8; k < 15; k = k + 1) begin
			rd(rows[k][23:16]);
			chk(reg_rdata, rows[k][7:0]);
		end
		summarize;
	end
endmodule
`default_nettype wire
